// ===== hdl/msc_checker.sv
`timescale 1ns/1ps
module msc_checker
   import msc_pkg::*;
#(
   parameter int PCNT_W = 20,
   parameter int TO_W   = 24,
   parameter int SEC_W  = 16
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_nrst,
   input  wire logic [ADDR_W-1:0] i_bus_addr,
   input  wire logic [DATA_W-1:0] i_bus_wdata,
   input  wire logic [BE_W-1:0]   i_bus_be,
   input  wire logic              i_bus_wr,
   input  wire logic              i_bus_rd,
   output logic      [DATA_W-1:0] o_bus_rdata,
   output logic                   o_dma_req,
   output msc_irq_t               o_irq
);

   // ------------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------------
   if (PCNT_W < 1 || PCNT_W > 32 || TO_W < 1 || TO_W > 32 || SEC_W < 1 || SEC_W > 32) begin : g_bad_width
      $error("msc_checker: counter widths must be 1..32");
   end

   // ------------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------------
   // One parallel step: every stage shifts once and takes its data bit
   function automatic logic [63:0] sig_step(input logic [63:0] s, input logic [63:0] d);
      logic [63:0] fb;
      fb = s[63] ? SIG_POLY : RST_ZERO64;
      sig_step = {s[62:0], 1'b0} ^ fb ^ d;
   endfunction

   // Byte enables expanded to a lane mask
   function automatic logic [63:0] lane_mask(input logic [7:0] be);
      logic [63:0] m;
      m = RST_ZERO64;
      for (int i = 0; i < 8; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      lane_mask = m;
   endfunction

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   logic [1:0]        mode_r;
   logic              auto_prev_r;
   logic [EV_W-1:0]   int_en_r;
   logic [EV_W-1:0]   flags_r;
   logic [EV_W-1:0]   flags_nxt;
   logic [PCNT_W-1:0] pcnt_set_r;
   logic [PCNT_W-1:0] pcnt_r;
   logic [TO_W-1:0]   wdog_pre_r;
   logic [TO_W-1:0]   block_pre_r;
   logic [TO_W-1:0]   to_cnt_r;
   msc_to_state_t     to_st_r;
   logic [63:0]       run_sig_r;
   logic [63:0]       sec_sig_r;
   logic [63:0]       expected_r;
   logic              exp_fresh_r;
   logic              exp_fresh_at_end_r;
   logic [SEC_W-1:0]  sec_num_r;
   logic [SEC_W-1:0]  cur_sec_r;
   logic              cur_read_r;
   logic              cmp_pend_r;
   logic              dma_req_r;
   logic [63:0]       rdata_r;

   // ------------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------------
   // Write strobes per register, plus the one read strobe for the current-sector register
   wire auto_mode   = (mode_r == MODE_AUTO);
   wire wr_gc       = i_bus_wr && (i_bus_addr == OFS_GLOBAL_CTRL);
   wire wr_ie       = i_bus_wr && (i_bus_addr == OFS_INT_ENABLE);
   wire wr_st       = i_bus_wr && (i_bus_addr == OFS_STATUS);
   wire wr_pc       = i_bus_wr && (i_bus_addr == OFS_PATTERN_CNT);
   wire wr_wp       = i_bus_wr && (i_bus_addr == OFS_WDOG_PRELOAD);
   wire wr_bp       = i_bus_wr && (i_bus_addr == OFS_BLOCK_PRELD);
   wire wr_sig      = i_bus_wr && (i_bus_addr == OFS_RUNNING_SIG);
   wire wr_exp      = i_bus_wr && (i_bus_addr == OFS_EXPECTED);
   wire rd_cur      = i_bus_rd && (i_bus_addr == OFS_CUR_SECTOR);
   wire sw_rst      = wr_gc && i_bus_wdata[GC_SWRST_BIT];

   // Narrow running-signature writes see zeros in unwritten lanes
   wire [63:0] pattern  = i_bus_wdata & lane_mask(i_bus_be);
   wire [63:0] sig_next = sig_step(run_sig_r, pattern);

   // Sector ends on the auto-mode write that finds the pattern counter at one; the counter then reloads
   wire sector_end  = auto_mode && wr_sig && (pcnt_r == PCNT_W'(1));
   wire enter_auto  = auto_mode && !auto_prev_r;
   wire mismatch    = cmp_pend_r && (sec_sig_r != expected_r);
   wire to_expire   = (to_st_r != MSC_TO_IDLE) && (to_cnt_r == TO_W'(1));

   // ------------------------------------------------------------------------
   // Event flags
   // ------------------------------------------------------------------------
   // A hardware set outranks a software clear in the same cycle
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;
   always_comb begin
      ev_set = '0;
      ev_clr = wr_st ? i_bus_wdata[EV_W-1:0] : '0;
      ev_set[EV_FAIL]     = auto_mode && mismatch;
      ev_set[EV_OVERRUN]  = auto_mode && mismatch && flags_r[EV_FAIL] && !cur_read_r;
      ev_set[EV_UNDERRUN] = auto_mode && cmp_pend_r && !exp_fresh_at_end_r;
      ev_set[EV_TIMEOUT]  = auto_mode && to_expire;
      flags_nxt = (flags_r & ~ev_clr) | ev_set;
   end

   // Interrupts need auto mode and the matching enable
   assign o_irq = msc_irq_t'(auto_mode ? (flags_r & int_en_r) : '0);
   assign o_dma_req = dma_req_r;

   // ------------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------------
   // Software settings, the auto-mode history bit and the event flags
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_r      <= MODE_FULL_CPU;
         auto_prev_r <= 1'b0;
         int_en_r    <= '0;
         pcnt_set_r  <= '0;
         wdog_pre_r  <= '0;
         block_pre_r <= '0;
         flags_r     <= '0;
      end else begin
         if (wr_gc) mode_r <= i_bus_wdata[GC_MODE_LSB +: 2];
         auto_prev_r <= auto_mode;
         if (wr_ie) int_en_r <= i_bus_wdata[EV_W-1:0];
         if (wr_pc) pcnt_set_r <= i_bus_wdata[PCNT_W-1:0];
         if (wr_wp) wdog_pre_r <= i_bus_wdata[TO_W-1:0];
         if (wr_bp) block_pre_r <= i_bus_wdata[TO_W-1:0];
         flags_r <= flags_nxt;
      end
   end

   // ------------------------------------------------------------------------
   // Signature path
   // ------------------------------------------------------------------------
   // Running and sector signatures
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         run_sig_r <= RST_ZERO64;
         sec_sig_r <= RST_ZERO64;
      end else if (sw_rst) begin
         run_sig_r <= RST_ZERO64;
      end else if (sector_end) begin
         sec_sig_r <= sig_next;
         run_sig_r <= RST_ZERO64;
      end else if (wr_sig) begin
         run_sig_r <= sig_next;
      end
   end

   // Pattern counter; idle outside auto mode so full-CPU counts nothing
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pcnt_r <= '0;
      end else if (!auto_mode || enter_auto || wr_pc) begin
         pcnt_r <= wr_pc ? i_bus_wdata[PCNT_W-1:0] : pcnt_set_r;
      end else if (sector_end) begin
         pcnt_r <= pcnt_set_r;
      end else if (wr_sig && pcnt_r != '0) begin
         pcnt_r <= pcnt_r - PCNT_W'(1);
      end
   end

   // ------------------------------------------------------------------------
   // Compare and request sequencing
   // ------------------------------------------------------------------------
   // Compare runs the cycle after the sector signature is saved
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmp_pend_r         <= 1'b0;
         exp_fresh_r        <= 1'b0;
         exp_fresh_at_end_r <= 1'b0;
         dma_req_r          <= 1'b0;
         sec_num_r          <= '0;
         cur_sec_r          <= '0;
         cur_read_r         <= 1'b1;
         expected_r         <= RST_ZERO64;
      end else begin
         cmp_pend_r <= sector_end;
         if (sector_end) exp_fresh_at_end_r <= exp_fresh_r;
         // Request on entering auto and after every comparison
         dma_req_r  <= auto_mode && (enter_auto || cmp_pend_r);
         if (wr_exp) begin
            expected_r  <= i_bus_wdata;
            exp_fresh_r <= 1'b1;
         end else if (sector_end || enter_auto) begin
            exp_fresh_r <= 1'b0;
         end
         if (enter_auto) sec_num_r <= '0;
         else if (cmp_pend_r) sec_num_r <= sec_num_r + SEC_W'(1);
         // A new failure reloads the register and re-arms the unread mark
         if (auto_mode && mismatch) begin
            cur_sec_r  <= sec_num_r;
            cur_read_r <= 1'b0;
         end else if (rd_cur) begin
            cur_read_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Timeout counter
   // ------------------------------------------------------------------------
   // Watchdog runs from request to expected-value delivery, then block timer
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         to_st_r  <= MSC_TO_IDLE;
         to_cnt_r <= '0;
      end else if (!auto_mode) begin
         to_st_r  <= MSC_TO_IDLE;
         to_cnt_r <= '0;
      end else if (dma_req_r) begin
         to_st_r  <= (wdog_pre_r != '0) ? MSC_TO_WDOG : MSC_TO_IDLE;
         to_cnt_r <= wdog_pre_r;
      end else if (wr_exp) begin
         to_st_r  <= (block_pre_r != '0) ? MSC_TO_BLOCK : MSC_TO_IDLE;
         to_cnt_r <= block_pre_r;
      end else begin
         case (to_st_r)
            MSC_TO_WDOG, MSC_TO_BLOCK: begin
               // Stops at zero; the step into zero is the timeout event
               to_cnt_r <= to_cnt_r - TO_W'(1);
               if (to_expire) to_st_r <= MSC_TO_IDLE;
            end
            MSC_TO_IDLE: begin
               to_cnt_r <= to_cnt_r;
            end
            default: begin
               to_st_r <= MSC_TO_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------------
   // Registered one cycle after the read strobe; unmapped reads give zero
   logic [63:0] rd_mux;
   always_comb begin
      case (i_bus_addr)
         OFS_GLOBAL_CTRL:  rd_mux = 64'(mode_r) << GC_MODE_LSB;
         OFS_INT_ENABLE:   rd_mux = 64'(int_en_r);
         OFS_STATUS:       rd_mux = 64'(flags_r);
         OFS_PATTERN_CNT:  rd_mux = 64'(pcnt_set_r);
         OFS_WDOG_PRELOAD: rd_mux = 64'(wdog_pre_r);
         OFS_BLOCK_PRELD:  rd_mux = 64'(block_pre_r);
         OFS_RUNNING_SIG:  rd_mux = run_sig_r;
         OFS_SECTOR_SIG:   rd_mux = sec_sig_r;
         OFS_EXPECTED:     rd_mux = expected_r;
         OFS_CUR_SECTOR:   rd_mux = 64'(cur_sec_r);
         OFS_COUNTERS:     rd_mux = {32'(to_cnt_r), 32'(pcnt_r)};
         default:          rd_mux = RST_ZERO64;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) rdata_r <= RST_ZERO64;
      else rdata_r <= i_bus_rd ? rd_mux : RST_ZERO64;
   end
   assign o_bus_rdata = rdata_r;

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   no_irq_cpu_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      !auto_mode |-> o_irq == '0) else $error("interrupt outside auto mode");
   irq_enable_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      o_irq.fail |-> int_en_r[EV_FAIL]) else $error("fail irq without enable");
   fail_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      sector_end ##1 (sec_sig_r != expected_r) |=> flags_r[EV_FAIL]) else $error("fail flag not set");
   cur_sector_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (auto_mode && mismatch) |=> cur_sec_r == $past(sec_num_r)) else $error("sector not stored");
   overrun_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (auto_mode && mismatch && flags_r[EV_FAIL] && !cur_read_r) |=> flags_r[EV_OVERRUN])
      else $error("overrun missed");
   sector_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      sector_end && !sw_rst |=> run_sig_r == RST_ZERO64 && sec_sig_r == $past(sig_next))
      else $error("sector save wrong");
   req_after_cmp_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      sector_end && auto_mode ##1 auto_mode |=> o_dma_req) else $error("no request after compare");
   no_req_cpu_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      !$past(auto_mode) |-> !o_dma_req || $past(enter_auto)) else $error("request in full-cpu");
   sw_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      sw_rst |=> run_sig_r == RST_ZERO64) else $error("software reset ignored");
   first_req_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      enter_auto |=> o_dma_req) else $error("no first request");
   irq_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (EV_W'(o_irq) & ~int_en_r) == '0) else $error("interrupt without enable");
   underrun_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      sector_end && !exp_fresh_r |-> ##2 flags_r[EV_UNDERRUN]) else $error("underrun missed");
   wdog_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      auto_mode && dma_req_r |=> to_cnt_r == $past(wdog_pre_r)) else $error("watchdog not reloaded");
   block_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      auto_mode && wr_exp && !dma_req_r |=> to_cnt_r == $past(block_pre_r))
      else $error("block timer not reloaded");
   timeout_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      auto_mode && to_st_r != MSC_TO_IDLE && to_cnt_r == TO_W'(1) |=> flags_r[EV_TIMEOUT])
      else $error("timeout missed");
   timer_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      auto_mode && to_st_r == MSC_TO_IDLE && !dma_req_r && !wr_exp |=> $stable(to_cnt_r))
      else $error("idle timer moved");
   upper_cmp_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      cmp_pend_r && auto_mode && sec_sig_r[63:32] != expected_r[63:32] |=> flags_r[EV_FAIL])
      else $error("upper half not compared");

endmodule

// ===== inc/msc_pkg.sv
// ---------------------------------------------------------------------------
// Memory signature checker shared definitions
// ---------------------------------------------------------------------------
package msc_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 64;
   localparam int BE_W   = 8;

   // Register offsets (byte addresses, one 64-bit word each)
   localparam logic [7:0] OFS_GLOBAL_CTRL  = 8'h00;
   localparam logic [7:0] OFS_INT_ENABLE   = 8'h08;
   localparam logic [7:0] OFS_STATUS       = 8'h10;
   localparam logic [7:0] OFS_PATTERN_CNT  = 8'h18;
   localparam logic [7:0] OFS_WDOG_PRELOAD = 8'h20;
   localparam logic [7:0] OFS_BLOCK_PRELD  = 8'h28;
   localparam logic [7:0] OFS_RUNNING_SIG  = 8'h30;
   localparam logic [7:0] OFS_SECTOR_SIG   = 8'h38;
   localparam logic [7:0] OFS_EXPECTED     = 8'h40;
   localparam logic [7:0] OFS_CUR_SECTOR   = 8'h48;
   localparam logic [7:0] OFS_COUNTERS     = 8'h50;

   // Global control fields
   localparam int GC_SWRST_BIT = 0;
   localparam int GC_MODE_LSB  = 1;
   localparam logic [1:0] MODE_FULL_CPU = 2'h0;
   localparam logic [1:0] MODE_AUTO     = 2'h1;

   // Status / enable bit positions
   localparam int EV_FAIL     = 0;
   localparam int EV_OVERRUN  = 1;
   localparam int EV_UNDERRUN = 2;
   localparam int EV_TIMEOUT  = 3;
   localparam int EV_W        = 4;

   // Feedback taps of x^64 + x^4 + x^3 + x + 1 (x^64 term implicit)
   localparam logic [63:0] SIG_POLY = 64'h0000_0000_0000_001B;

   // Reset values
   localparam logic [63:0] RST_ZERO64 = 64'h0000_0000_0000_0000;

   // Timeout counter phase
   typedef enum logic [1:0] {
      MSC_TO_IDLE  = 2'b00,
      MSC_TO_WDOG  = 2'b01,
      MSC_TO_BLOCK = 2'b10
   } msc_to_state_t;

   // Interrupt outputs bundled
   typedef struct packed {
      logic timeout;
      logic underrun;
      logic overrun;
      logic fail;
   } msc_irq_t;

endpackage

// ===== verif/msc_dma_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Delivery side of the checker: answers each request not dropped by skip with one expected value
// ---------------------------------------------------------------------------
module msc_dma_model
   import msc_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_dma_req,
   input  wire logic [DATA_W-1:0] i_next_val,
   input  wire logic [7:0]        i_delay,
   input  wire logic              i_skip,
   output logic                   o_wr,
   output logic      [DATA_W-1:0] o_wdata
);
   logic [7:0] wait_r;
   logic       pend_r;

   // Delay before delivery is set by the bench; skip drops a request on purpose
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pend_r  <= 1'b0;
         wait_r  <= 8'h00;
         o_wr    <= 1'b0;
         o_wdata <= 64'h0;
      end else begin
         o_wr    <= 1'b0;
         o_wdata <= ~o_wdata;  // Idle data keeps changing so a stale value is never read as valid
         if (i_dma_req && !i_skip) begin
            pend_r <= 1'b1;
            wait_r <= i_delay;
         end else if (pend_r && wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
         end else if (pend_r) begin
            pend_r  <= 1'b0;
            o_wr    <= 1'b1;
            o_wdata <= i_next_val;
         end
      end
   end
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb
   import msc_pkg::*;
;
   logic              i_ref_clk;
   logic              i_nrst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, next_val, exp_v, dat, s_cur, sig, dma_wdata;
   logic [DATA_W-1:0] d_arr [3];
   logic [BE_W-1:0]   be;
   logic              wr, rd, dma_req, dma_wr, skip, cpu_phase;
   logic              rd_d = 1'b0;
   logic [7:0]        delay;
   logic [31:0]       lfsr;
   msc_irq_t          irq;
   logic [DATA_W-1:0] exp_q [$];
   logic [BE_W-1:0]   be_tab [5] = '{8'hFF, 8'h0F, 8'hF0, 8'h03, 8'h80};
   int                fail_count, checked, req_count, dma_count;

   // ---------------------------------------------------------------------------
   // Design, delivery model and clock
   // ---------------------------------------------------------------------------
   // Model writes win the bus; the bench keeps quiet while a delivery is due
   msc_checker u_msc_checker (
      .i_ref_clk   (i_ref_clk),
      .i_nrst      (i_nrst),
      .i_bus_addr  (dma_wr ? OFS_EXPECTED : addr),
      .i_bus_wdata (dma_wr ? dma_wdata : wdata),
      .i_bus_be    (dma_wr ? 8'hFF : be),
      .i_bus_wr    (wr | dma_wr),
      .i_bus_rd    (rd),
      .o_bus_rdata (rdata),
      .o_dma_req   (dma_req),
      .o_irq       (irq)
   );
   msc_dma_model u_msc_dma_model (
      .i_ref_clk  (i_ref_clk),
      .i_nrst     (i_nrst),
      .i_dma_req  (dma_req),
      .i_next_val (next_val),
      .i_delay    (delay),
      .i_skip     (skip),
      .o_wr       (dma_wr),
      .o_wdata    (dma_wdata)
   );
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   // ---------------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------------
   function automatic logic [31:0] lfsr_step(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [63:0] rnd64();
      logic [31:0] hi;
      lfsr = lfsr_step(lfsr);
      hi = lfsr;
      lfsr = lfsr_step(lfsr);
      return {hi, lfsr};
   endfunction
   // Reference signature step, unwritten lanes forced to zero
   function automatic logic [63:0] sig_step(input logic [63:0] s, d, input logic [7:0] b);
      logic [63:0] m;
      for (int i = 0; i < 8; i++) m[8*i +: 8] = {8{b[i]}};
      return {s[62:0], 1'b0} ^ (s[63] ? SIG_POLY : RST_ZERO64) ^ (d & m);
   endfunction
   task automatic err(input string m);
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   // Levels are looked at mid-cycle, after the edge's updates have landed
   task automatic chk(input logic [3:0] e);
      @(negedge i_ref_clk);
      checked++;
      if (irq !== e) err("interrupt level");
   endtask
   task automatic bus_w(input logic [7:0] a, input logic [63:0] d, input logic [7:0] b);
      @(posedge i_ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      be <= b;
      @(posedge i_ref_clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask
   task automatic bus_r(input logic [7:0] a, input logic [63:0] e);
      @(posedge i_ref_clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge i_ref_clk);
      rd <= 1'b0;
   endtask
   task automatic test_done();
      repeat (3) @(posedge i_ref_clk);
      if (fail_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Bounded wait on the request or delivery count
   task automatic wait_for(input logic use_dma, input int n);
      for (int k = 0; k < 60; k++) begin
         if ((use_dma ? dma_count : req_count) >= n) return;
         @(posedge i_ref_clk);
      end
      err("request or delivery missing");
      test_done();
   endtask
   // Three patterns per sector; the next expected value is queued for the model
   task automatic prep(input logic bad);
      s_cur = RST_ZERO64;
      for (int i = 0; i < 3; i++) begin
         d_arr[i] = rnd64();
         s_cur = sig_step(s_cur, d_arr[i], 8'hFF);
      end
      next_val <= bad ? s_cur ^ 64'h8000_0000_0000_0000 : s_cur;
   endtask
   task automatic feed();
      for (int i = 0; i < 3; i++) bus_w(OFS_RUNNING_SIG, d_arr[i], 8'hFF);
   endtask

   // Read data stands only in the cycle after the strobe, so it is taken there
   always @(posedge i_ref_clk) begin
      rd_d <= rd;
      if (dma_req === 1'b1) req_count <= req_count + 1;
      if (dma_wr === 1'b1) dma_count <= dma_count + 1;
      if (rd_d === 1'b1) begin
         exp_v = exp_q.pop_front();
         checked++;
         if (rdata !== exp_v) err("read data");
      end
      if (cpu_phase && (dma_req !== 1'b0 || irq !== 4'h0)) err("activity in cpu mode");
   end

   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial begin
      i_nrst = 1'b0;
      {wr, rd, skip, cpu_phase} = 4'h0;
      addr = 8'h00;
      wdata = RST_ZERO64;
      be = 8'h00;
      next_val = RST_ZERO64;
      delay = 8'h08;
      lfsr = 32'h0000_092F;
      sig = RST_ZERO64;
      {fail_count, checked, req_count, dma_count} = {4{32'h0}};
      repeat (16) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      cpu_phase <= 1'b1;
      bus_r(OFS_STATUS, RST_ZERO64);
      bus_r(OFS_RUNNING_SIG, RST_ZERO64);
      bus_r(8'h58, RST_ZERO64);
      bus_w(OFS_INT_ENABLE, 64'hF, 8'hFF);
      bus_w(OFS_PATTERN_CNT, 64'h3, 8'hFF);
      for (int i = 0; i < 5; i++) begin
         dat = rnd64();
         sig = sig_step(sig, dat, be_tab[i]);
         bus_w(OFS_RUNNING_SIG, dat, be_tab[i]);
      end
      bus_r(OFS_RUNNING_SIG, sig);
      bus_r(OFS_COUNTERS, 64'h3);
      bus_w(OFS_GLOBAL_CTRL, 64'h1, 8'hFF);
      bus_r(OFS_RUNNING_SIG, RST_ZERO64);
      cpu_phase <= 1'b0;
      prep(1'b0);
      bus_w(OFS_GLOBAL_CTRL, 64'h2, 8'hFF);
      wait_for(1'b0, 1);
      wait_for(1'b1, 1);
      feed();
      bus_r(OFS_SECTOR_SIG, s_cur);
      bus_r(OFS_RUNNING_SIG, RST_ZERO64);
      prep(1'b1);
      wait_for(1'b0, 2);
      bus_r(OFS_STATUS, RST_ZERO64);
      wait_for(1'b1, 2);
      feed();
      prep(1'b1);
      wait_for(1'b0, 3);
      bus_r(OFS_STATUS, 64'h1);
      chk(4'h1);
      bus_r(OFS_CUR_SECTOR, 64'h1);
      wait_for(1'b1, 3);
      feed();
      prep(1'b1);
      wait_for(1'b0, 4);
      wait_for(1'b1, 4);
      bus_r(OFS_STATUS, 64'h1);
      feed();
      prep(1'b0);
      wait_for(1'b0, 5);
      bus_r(OFS_STATUS, 64'h3);
      chk(4'h3);
      wait_for(1'b1, 5);
      bus_w(OFS_INT_ENABLE, 64'h2, 8'hFF);
      chk(4'h2);
      bus_w(OFS_INT_ENABLE, 64'hF, 8'hFF);
      bus_w(OFS_STATUS, 64'hF, 8'hFF);
      bus_r(OFS_STATUS, RST_ZERO64);
      // Model drops the next two requests, so the following sector runs on a stale value
      skip <= 1'b1;
      feed();
      prep(1'b0);
      wait_for(1'b0, 6);
      bus_r(OFS_STATUS, RST_ZERO64);
      feed();
      wait_for(1'b0, 7);
      bus_r(OFS_STATUS, 64'h5);
      skip <= 1'b0;
      bus_w(OFS_STATUS, 64'hF, 8'hFF);
      prep(1'b0);
      bus_w(OFS_EXPECTED, s_cur, 8'hFF);
      bus_w(OFS_WDOG_PRELOAD, 64'h8, 8'hFF);
      delay <= 8'h1E;
      feed();
      wait_for(1'b0, 8);
      bus_r(OFS_STATUS, RST_ZERO64);
      repeat (12) @(posedge i_ref_clk);
      bus_r(OFS_STATUS, 64'h8);
      wait_for(1'b1, 6);
      bus_w(OFS_STATUS, 64'hF, 8'hFF);
      bus_w(OFS_WDOG_PRELOAD, RST_ZERO64, 8'hFF);
      bus_w(OFS_BLOCK_PRELD, 64'h0100_0006, 8'hFF);
      bus_w(OFS_EXPECTED, RST_ZERO64, 8'hFF);
      bus_r(OFS_STATUS, RST_ZERO64);
      repeat (8) @(posedge i_ref_clk);
      bus_r(OFS_STATUS, 64'h8);
      bus_w(OFS_GLOBAL_CTRL, RST_ZERO64, 8'hFF);
      chk(4'h0);
      test_done();
   end
endmodule
